// File: verilog/flash_read_pkg.sv
package flash_read_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
   localparam logic [7:0] OP_QUAD_WORD_READ = 8'hE7;
   localparam logic [7:0] OP_OCTAL_WORD_READ = 8'hE3;
   localparam logic [7:0] OP_SET_WRAP = 8'h77;
   localparam logic [7:0] OP_WRAP_READ = 8'h0C;
   localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
   localparam logic [7:0] OP_CONT_MODE_RESET = 8'hFF;

   // ------------------------------------------------------------
   // phase lengths in serial clocks (LAST values = length - 1, DUMMY values = length)
   // ------------------------------------------------------------
   localparam logic [5:0] SPI_OPC_LAST = 6'h07;
   localparam logic [5:0] QPI_OPC_LAST = 6'h01;
   localparam logic [5:0] ADDR_LAST = 6'h05;
   localparam logic [5:0] MODE_LAST = 6'h01;
   localparam logic [5:0] PARAM_LAST = 6'h01;
   localparam logic [5:0] WRAP_SET_LAST = 6'h1F;
   localparam logic [5:0] DUMMY_QUAD_READ = 6'h04;
   localparam logic [5:0] DUMMY_WORD_READ = 6'h02;
   localparam logic [5:0] DUMMY_OCTAL_READ = 6'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SKIP_HI = 5;
   localparam int SKIP_LO = 4;
   localparam logic [1:0] SKIP_MATCH = 2'b10;
   localparam int WRAP_DIS_POS = 4;
   localparam int WRAP_LEN_HI = 6;
   localparam int WRAP_LEN_LO = 5;
   localparam int PARAM_DUMMY_HI = 5;
   localparam int PARAM_DUMMY_LO = 4;
   localparam int PARAM_WLEN_HI = 1;
   localparam int PARAM_WLEN_LO = 0;

   // ------------------------------------------------------------
   // reset values and masks
   // ------------------------------------------------------------
   localparam logic WRAP_DIS_RST = 1'b1;
   localparam logic [1:0] WRAP_LEN_RST = 2'b00;
   localparam logic [1:0] PARAM_DUMMY_RST = 2'b00;
   localparam logic [1:0] PARAM_WLEN_RST = 2'b00;
   localparam logic [23:0] WORD_ADDR_MASK = 24'hFF_FFFE;
   localparam logic [23:0] OCTAL_ADDR_MASK = 24'hFF_FFF0;
   localparam logic [7:0] WRAP_MASK_8 = 8'h07;
   localparam logic [7:0] WRAP_MASK_16 = 8'h0F;
   localparam logic [7:0] WRAP_MASK_32 = 8'h1F;
   localparam logic [7:0] WRAP_MASK_64 = 8'h3F;

endpackage

// File: verilog/sclk_edge.sv
`timescale 1ns/1ps

module sclk_edge (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // sampled pin and its edges
   input wire logic pin,
   output logic rise,
   output logic fall
);

   logic prev_q;
   logic prev_d;

   // ------------------------------------------------------------
   // previous level of the pin
   // ------------------------------------------------------------
   always_comb begin
      prev_d = pin;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   // edges are combinational so a phase step lands on the same cycle
   assign rise = pin & ~prev_q;
   assign fall = ~pin & prev_q;

endmodule

// File: verilog/wrap_addr_next.sv
`timescale 1ns/1ps

module wrap_addr_next import flash_read_pkg::*; (
   // current address and wrap control
   input wire logic [23:0] addr,
   input wire logic wrap_en,
   input wire logic [1:0] len_sel,
   // following byte address
   output logic [23:0] next_addr
);

   logic [23:0] inc;
   logic [7:0] mask;

   // ------------------------------------------------------------
   // linear or section-confined increment
   // ------------------------------------------------------------
   always_comb begin
      inc = addr + 24'h00_0001;
      case (len_sel)
         2'b00: mask = WRAP_MASK_8;
         2'b01: mask = WRAP_MASK_16;
         2'b10: mask = WRAP_MASK_32;
         default: mask = WRAP_MASK_64;
      endcase
      // sections never exceed a page, so bits above 7 stay put
      if (wrap_en) begin
         next_addr = {addr[23:8], (addr[7:0] & ~mask) | (inc[7:0] & mask)};
      end else begin
         next_addr = inc;
      end
   end

endmodule

// File: verilog/quad_io_read_wrap_engine.sv
`timescale 1ns/1ps

// Behaviour
// - quad read takes opcode, 24-bit address, mode byte, four dummies, nibble-wide.
// - data leaves four bits per clock; address steps by one each byte.
// - quad read is refused unless quad enable is set.
// - mode skip bits 10 on quad read make the next transaction opcode-free.
// - a continuous-mode reset instruction clears the captured skip state in single line command mode; its eight io0 clocks end a mode byte with skip bits 01.
// - enabled wrap keeps reads inside an aligned section until select rises.
// - word read forces address bit 0 low, two dummies, needs quad enable.
// - word read skip bits 10 let the next transaction omit its opcode.
// - octal word read forces low four address bits low, no dummies.
// - octal word read is refused unless quad enable is set.
// - octal mode byte upper nibble decides skipping, lower nibble ignored.
// - skipping octal read takes the address right after select falls.
// - set-wrap is opcode, 24 dummy bits, wrap byte, single line mode only.
// - stored wrap setting governs later quad and word reads until rewritten.
// - wrap disable bit comes up as one, so wrapping is off.
// - length select 00..11 gives 8, 16, 32 or 64 byte sections.
// - four-wire wrap read acts like fast read but wraps at section end.
// - four-wire wrap read takes length and dummies from read parameters.
// - read parameter dummy field gives 2, 4, 6, 8 clocks, default 2.
module quad_io_read_wrap_engine import flash_read_pkg::*; (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   // configuration levels
   input wire logic quad_io_enable,
   input wire logic four_wire_command_mode,
   // memory array
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_data,
   // status
   output logic continuous_active,
   output logic wrap_disable_bit,
   output logic [1:0] wrap_length_select,
   output logic [1:0] read_dummy_select,
   output logic [1:0] read_wrap_select,
   output logic data_phase
);

   typedef enum logic [2:0] {
      ST_OPC,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_WRAPSET,
      ST_PARAM,
      ST_IGNORE
   } state_t;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   state_t state_q;
   state_t state_d;
   logic [5:0] cnt_q;
   logic [5:0] cnt_d;
   logic [31:0] sr_q;
   logic [31:0] sr_d;
   logic [7:0] op_q;
   logic [7:0] op_d;
   logic [23:0] addr_q;
   logic [23:0] addr_d;
   logic nib_q;
   logic nib_d;
   logic [3:0] hold_q;
   logic [3:0] hold_d;
   logic [3:0] out_q;
   logic [3:0] out_d;
   logic oe_q;
   logic oe_d;
   logic cont_q;
   logic cont_d;
   logic wdis_q;
   logic wdis_d;
   logic [1:0] wlen_q;
   logic [1:0] wlen_d;
   logic [1:0] pdum_q;
   logic [1:0] pdum_d;
   logic [1:0] pwlen_q;
   logic [1:0] pwlen_d;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic rise;
   logic fall;
   logic [31:0] sr1;
   logic [31:0] sr4;
   logic [31:0] sr_opc;
   logic [5:0] opc_last;
   logic [5:0] dummy_need;
   logic wrap_en;
   logic [1:0] len_sel;
   logic [23:0] next_addr;
   logic [23:0] addr_mask;

   sclk_edge sclk_edge_i (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(sclk),
      .rise(rise),
      .fall(fall)
   );

   wrap_addr_next wrap_addr_next_i (
      .addr(addr_q),
      .wrap_en(wrap_en),
      .len_sel(len_sel),
      .next_addr(next_addr)
   );

   // sampling is on rising clock edges, one or four lines wide
   assign sr1 = {sr_q[30:0], io_in[0]};
   assign sr4 = {sr_q[27:0], io_in};
   assign sr_opc = four_wire_command_mode ? sr4 : sr1;
   assign opc_last = four_wire_command_mode ? QPI_OPC_LAST : SPI_OPC_LAST;

   // ------------------------------------------------------------
   // per-instruction dummy length, address alignment and wrap source
   // ------------------------------------------------------------
   always_comb begin
      dummy_need = DUMMY_OCTAL_READ;
      addr_mask = 24'hFF_FFFF;
      wrap_en = 1'b0;
      len_sel = wlen_q;
      case (op_q)
         OP_QUAD_IO_READ: begin
            dummy_need = DUMMY_QUAD_READ;
            wrap_en = ~wdis_q;
         end
         OP_QUAD_WORD_READ: begin
            dummy_need = DUMMY_WORD_READ;
            addr_mask = WORD_ADDR_MASK;
            wrap_en = ~wdis_q;
         end
         OP_OCTAL_WORD_READ: begin
            dummy_need = DUMMY_OCTAL_READ;
            addr_mask = OCTAL_ADDR_MASK;
         end
         OP_WRAP_READ: begin
            // dummies are 2 * (field + 1)
            dummy_need = {3'b000, pdum_q, 1'b0} + 6'h02;
            wrap_en = 1'b1;
            len_sel = pwlen_q;
         end
         default: begin
            dummy_need = DUMMY_OCTAL_READ;
         end
      endcase
   end

   // ------------------------------------------------------------
   // sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      sr_d = sr_q;
      op_d = op_q;
      addr_d = addr_q;
      nib_d = nib_q;
      hold_d = hold_q;
      out_d = out_q;
      oe_d = oe_q;
      cont_d = cont_q;
      wdis_d = wdis_q;
      wlen_d = wlen_q;
      pdum_d = pdum_q;
      pwlen_d = pwlen_q;
      if (cs_n) begin
         // deselect ends everything; a pending skip resumes at the address
         state_d = cont_q ? ST_ADDR : ST_OPC;
         cnt_d = 6'h00;
         nib_d = 1'b0;
         oe_d = 1'b0;
      end else if (rise) begin
         case (state_q)
            ST_OPC: begin
               sr_d = sr_opc;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == opc_last) begin
                  cnt_d = 6'h00;
                  op_d = sr_opc[7:0];
                  case (sr_opc[7:0])
                     OP_QUAD_IO_READ, OP_QUAD_WORD_READ, OP_OCTAL_WORD_READ: begin
                        state_d = quad_io_enable ? ST_ADDR : ST_IGNORE;
                     end
                     OP_WRAP_READ: begin
                        state_d = four_wire_command_mode ? ST_ADDR : ST_IGNORE;
                     end
                     OP_SET_WRAP: begin
                        state_d = four_wire_command_mode ? ST_IGNORE : ST_WRAPSET;
                     end
                     OP_SET_READ_PARAM: begin
                        state_d = four_wire_command_mode ? ST_PARAM : ST_IGNORE;
                     end
                     OP_CONT_MODE_RESET: begin
                        cont_d = 1'b0;
                        state_d = ST_IGNORE;
                     end
                     default: begin
                        state_d = ST_IGNORE;
                     end
                  endcase
               end
            end
            ST_ADDR: begin
               sr_d = sr4;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == ADDR_LAST) begin
                  cnt_d = 6'h00;
                  addr_d = sr4[23:0] & addr_mask;
                  state_d = (op_q == OP_WRAP_READ) ? ST_DUMMY : ST_MODE;
               end
            end
            ST_MODE: begin
               sr_d = sr4;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == MODE_LAST) begin
                  cnt_d = 6'h00;
                  // only the skip bits count; the low nibble is don't care
                  cont_d = (sr4[SKIP_HI:SKIP_LO] == SKIP_MATCH);
                  state_d = (dummy_need == 6'h00) ? ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == dummy_need - 6'h01) begin
                  cnt_d = 6'h00;
                  state_d = ST_DATA;
               end
            end
            ST_WRAPSET: begin
               sr_d = sr1;
               cnt_d = cnt_q + 6'h01;
               // early deselect drops the partial word without effect
               if (cnt_q == WRAP_SET_LAST) begin
                  cnt_d = 6'h00;
                  wdis_d = sr1[WRAP_DIS_POS];
                  wlen_d = sr1[WRAP_LEN_HI:WRAP_LEN_LO];
                  state_d = ST_IGNORE;
               end
            end
            ST_PARAM: begin
               sr_d = sr4;
               cnt_d = cnt_q + 6'h01;
               if (cnt_q == PARAM_LAST) begin
                  cnt_d = 6'h00;
                  pdum_d = sr4[PARAM_DUMMY_HI:PARAM_DUMMY_LO];
                  pwlen_d = sr4[PARAM_WLEN_HI:PARAM_WLEN_LO];
                  state_d = ST_IGNORE;
               end
            end
            ST_DATA, ST_IGNORE: begin
               state_d = state_q;
            end
            default: begin
               state_d = ST_IGNORE;
            end
         endcase
      end else if (fall && (state_q == ST_DATA)) begin
         // high nibble first; the low nibble is held so the array may move on
         oe_d = 1'b1;
         nib_d = ~nib_q;
         if (!nib_q) begin
            out_d = mem_data[7:4];
            hold_d = mem_data[3:0];
         end else begin
            out_d = hold_q;
            addr_d = next_addr;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_OPC;
         cnt_q <= 6'h00;
         sr_q <= 32'h0000_0000;
         op_q <= 8'h00;
         addr_q <= 24'h00_0000;
         nib_q <= 1'b0;
         hold_q <= 4'h0;
         out_q <= 4'h0;
         oe_q <= 1'b0;
         cont_q <= 1'b0;
         wdis_q <= WRAP_DIS_RST;
         wlen_q <= WRAP_LEN_RST;
         pdum_q <= PARAM_DUMMY_RST;
         pwlen_q <= PARAM_WLEN_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sr_q <= sr_d;
         op_q <= op_d;
         addr_q <= addr_d;
         nib_q <= nib_d;
         hold_q <= hold_d;
         out_q <= out_d;
         oe_q <= oe_d;
         cont_q <= cont_d;
         wdis_q <= wdis_d;
         wlen_q <= wlen_d;
         pdum_q <= pdum_d;
         pwlen_q <= pwlen_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign io_out = out_q;
   assign io_oe = {4{oe_q}}; // drives only after the first data falling edge
   assign mem_addr = addr_q;
   assign continuous_active = cont_q;
   assign wrap_disable_bit = wdis_q;
   assign wrap_length_select = wlen_q;
   assign read_dummy_select = pdum_q;
   assign read_wrap_select = pwlen_q;
   assign data_phase = (state_q == ST_DATA);

endmodule

// File: tb/quad_io_read_wrap_engine_props.sv
`timescale 1ns/1ps

module quad_io_read_wrap_engine_props (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   // levels
   input wire logic quad_io_enable,
   input wire logic four_wire_command_mode,
   // array
   input wire logic [23:0] mem_addr,
   input wire logic [7:0] mem_data,
   // status
   input wire logic continuous_active,
   input wire logic wrap_disable_bit,
   input wire logic [1:0] wrap_length_select,
   input wire logic [1:0] read_dummy_select,
   input wire logic [1:0] read_wrap_select,
   input wire logic data_phase
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ----
   // drive timing ties to serial clock falls, seen one cycle late
   // ----
   a_reset_vals:
      assert property (disable iff (1'b0) rst |=> io_oe == 4'h0 && wrap_disable_bit
         && !continuous_active && read_dummy_select == 2'b00) else $error("bad reset state");
   a_oe_select:
      assert property (cs_n |=> io_oe == 4'h0) else $error("drive after deselect");
   a_oe_in_data:
      assert property (io_oe[0] |-> data_phase && io_oe == 4'hF)
         else $error("drive outside data phase");
   a_oe_on_fall:
      assert property ($rose(io_oe[0]) |-> $past(sclk, 2) && !$past(sclk))
         else $error("drive not after a fall");
   a_out_on_fall:
      assert property ($changed(io_out) |-> $past(sclk, 2) && !$past(sclk))
         else $error("data moved off a fall");
   a_oe_needs_qe:
      assert property ($rose(io_oe[0]) && !four_wire_command_mode |-> quad_io_enable)
         else $error("read without quad enable");
   a_addr_step:
      assert property ($changed(mem_addr) && $past(io_oe[0]) && io_oe[0]
         |-> mem_addr[5:0] == $past(mem_addr[5:0]) + 6'h01 || mem_addr[2:0] == 3'h0)
         else $error("address step wrong");
   a_skip_on_rise:
      assert property ($changed(continuous_active) |-> $past(sclk) && !$past(sclk, 2))
         else $error("skip state off a rise");
   a_wrap_on_rise:
      assert property ($changed({wrap_disable_bit, wrap_length_select, read_wrap_select,
         read_dummy_select}) |-> $past(sclk) && !$past(sclk, 2)) else $error("setting moved");

   c_skip: cover property ($rose(continuous_active));
   c_wrap: cover property (io_oe[0] && !wrap_disable_bit);
   c_qpi: cover property (io_oe[0] && four_wire_command_mode);
endmodule

bind quad_io_read_wrap_engine quad_io_read_wrap_engine_props quad_io_read_wrap_engine_props_i (
   .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
   .io_oe(io_oe), .quad_io_enable(quad_io_enable),
   .four_wire_command_mode(four_wire_command_mode), .mem_addr(mem_addr),
   .mem_data(mem_data), .continuous_active(continuous_active),
   .wrap_disable_bit(wrap_disable_bit), .wrap_length_select(wrap_length_select),
   .read_dummy_select(read_dummy_select), .read_wrap_select(read_wrap_select),
   .data_phase(data_phase));

// File: tb/spi_host_model.sv
`timescale 1ns/1ps

module spi_host_model (
   // clock
   input wire logic clk_sys,
   // pins toward the device
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_in,
   // pins from the device
   input wire logic [3:0] io_out
);
   logic [3:0] last_q;
   logic [3:0] sampled;

   // ----
   // host side: deselected, clock parked low between frames
   // ----
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io_in = 4'h0;
      last_q = 4'h0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // nibble set up in the low half, answer taken at the rise
   task automatic pulse(input logic [3:0] nib);
      sclk = 1'b0;
      io_in = nib;
      last_q = nib;
      tick(3);
      sclk = 1'b1;
      sampled = io_out;
      tick(3);
   endtask

   // released lines show the inverse, so a stale level cannot pass
   task automatic idle();
      pulse(~last_q);
   endtask

   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) pulse(v[4*i+:4]);
   endtask

   // single-line byte on io0, msb first
   task automatic spi_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) pulse({3'b000, b[i]});
   endtask

   task automatic frame_start();
      tick(1);
      cs_n = 1'b0;
   endtask

   // clock low before deselect; the gap keeps frames apart
   task automatic frame_end();
      sclk = 1'b0;
      tick(3);
      cs_n = 1'b1;
      io_in = ~last_q;
      tick(2);
   endtask
endmodule

// File: tb/quad_io_read_wrap_engine_bench.sv
`timescale 1ns/1ps

module quad_io_read_wrap_engine_bench import flash_read_pkg::*; ;
   logic clk_sys, rst, cs_n, sclk, quad_io_enable, four_wire_command_mode;
   logic continuous_active, wrap_disable_bit, data_phase;
   logic [3:0] io_in, io_out, io_oe;
   logic [1:0] wrap_length_select, read_dummy_select, read_wrap_select;
   logic [23:0] mem_addr;
   logic [7:0] mem_data;
   int num_errors, checks_done;

   // array byte mixes in the top byte so a wrong top address byte shows; bits 15:8 do not affect it
   assign mem_data = mem_addr[7:0] ^ mem_addr[23:16];

   quad_io_read_wrap_engine quad_io_read_wrap_engine_i (
      .clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .quad_io_enable(quad_io_enable),
      .four_wire_command_mode(four_wire_command_mode), .mem_addr(mem_addr),
      .mem_data(mem_data), .continuous_active(continuous_active),
      .wrap_disable_bit(wrap_disable_bit), .wrap_length_select(wrap_length_select),
      .read_dummy_select(read_dummy_select), .read_wrap_select(read_wrap_select),
      .data_phase(data_phase));
   spi_host_model spi_host_model_i (
      .clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk), .io_in(io_in), .io_out(io_out));

   // ----
   // access tasks
   // ----
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      if (num_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic opcode(input logic [7:0] op);
      if (four_wire_command_mode) spi_host_model_i.send({24'h0, op}, 2);
      else spi_host_model_i.spi_byte(op);
   endtask

   // a walks the expected address; m marks the bits allowed to count
   task automatic rd(input logic [7:0] op, input bit skip, input logic [31:0] am,
         input int dum, input logic [23:0] a, input logic [23:0] m, input int n);
      logic [3:0] hi;
      spi_host_model_i.frame_start();
      if (!skip) opcode(op);
      spi_host_model_i.send(am, op == OP_WRAP_READ ? 6 : 8);
      repeat (dum) spi_host_model_i.idle();
      repeat (n) begin
         spi_host_model_i.idle();
         hi = spi_host_model_i.sampled;
         spi_host_model_i.idle();
         cmp({hi, spi_host_model_i.sampled}, a[7:0] ^ a[23:16]);
         a = (a & ~m) | ((a + 24'h1) & m);
      end
      spi_host_model_i.frame_end();
   endtask

   task automatic set_wrap(input logic [7:0] w);
      spi_host_model_i.frame_start();
      opcode(OP_SET_WRAP);
      repeat (3) spi_host_model_i.spi_byte(8'h00);
      spi_host_model_i.spi_byte(w);
      spi_host_model_i.frame_end();
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // a hang is cut short well past the expected run length
   initial begin
      #200_000;
      num_errors++;
      tally_and_finish();
   end

   // ----
   // test sequence
   // ----
   initial begin
      int sz;
      logic [23:0] a;
      num_errors = 0;
      checks_done = 0;
      rst = 1'b1;
      quad_io_enable = 1'b0;
      four_wire_command_mode = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1 rst = 1'b0;
      cmp({continuous_active, wrap_disable_bit, wrap_length_select, io_oe}, 8'h40);
      cmp({4'h0, read_dummy_select, read_wrap_select}, 8'h00);
      for (int k = 0; k < 2; k++) begin
         spi_host_model_i.frame_start();
         opcode(k ? OP_OCTAL_WORD_READ : OP_QUAD_IO_READ);
         spi_host_model_i.send(32'h1234_0000, 8);
         repeat (6) spi_host_model_i.idle();
         cmp({4'h0, io_oe}, 8'h00);
         spi_host_model_i.frame_end();
      end
      quad_io_enable = 1'b1;
      rd(OP_QUAD_IO_READ, 0, 32'h1234_FE20, 4, 24'h12_34FE, 24'hFF_FFFF, 3);
      cmp({7'h0, continuous_active}, 8'h01);
      rd(OP_QUAD_IO_READ, 1, 32'h2000_0100, 4, 24'h20_0001, 24'hFF_FFFF, 2);
      cmp({7'h0, continuous_active}, 8'h00);
      rd(OP_QUAD_WORD_READ, 0, 32'h2100_4720, 2, 24'h21_0046, 24'hFF_FFFF, 3);
      rd(OP_QUAD_WORD_READ, 1, 32'h2100_8900, 2, 24'h21_0088, 24'hFF_FFFF, 2);
      cmp({7'h0, continuous_active}, 8'h00);
      rd(OP_OCTAL_WORD_READ, 0, 32'h3A5A_5B2F, 0, 24'h3A_5A50, 24'hFF_FFFF, 2);
      rd(OP_OCTAL_WORD_READ, 1, 32'h3A00_17A5, 0, 24'h3A_0010, 24'hFF_FFFF, 2);
      cmp({7'h0, continuous_active}, 8'h01);
      // ones on io0 alone for eight clocks put a one in the low skip bit
      spi_host_model_i.frame_start();
      spi_host_model_i.spi_byte(8'hFF);
      spi_host_model_i.frame_end();
      cmp({7'h0, continuous_active}, 8'h00);
      // each length, started two bytes before its section end
      for (int len = 0; len < 4; len++) begin
         sz = 8 << len;
         set_wrap({1'b0, len[1:0], 5'h00});
         cmp({5'h0, wrap_disable_bit, wrap_length_select}, {6'h00, len[1:0]});
         a = 24'h44_5580 + 24'(sz) - 24'h2;
         rd(OP_QUAD_IO_READ, 0, {a, 8'h00}, 4, a, 24'(sz - 1), 4);
      end
      rd(OP_QUAD_WORD_READ, 0, 32'h4455_FF00, 2, 24'h44_55FE, 24'h00_003F, 3);
      set_wrap(8'h10);
      rd(OP_QUAD_IO_READ, 0, 32'h4455_FE00, 4, 24'h44_55FE, 24'hFF_FFFF, 3);
      four_wire_command_mode = 1'b1;
      set_wrap(8'h00);
      cmp({7'h0, wrap_disable_bit}, 8'h01);
      for (int s = 0; s < 4; s++) begin
         spi_host_model_i.frame_start();
         opcode(OP_SET_READ_PARAM);
         spi_host_model_i.send({26'h0, s[1:0], 2'b00, s[1:0]}, 2);
         spi_host_model_i.frame_end();
         cmp({4'h0, read_dummy_select, read_wrap_select}, {4'h0, s[1:0], s[1:0]});
         sz = 8 << s;
         a = 24'h66_7700 + 24'(sz) - 24'h3;
         rd(OP_WRAP_READ, 0, {8'h00, a}, 2 * (s + 1), a, 24'(sz - 1), 4);
      end
      tally_and_finish();
   end
endmodule
